/* File: hw/hpb_regs.svh */
// Constants for the host port half-word handshake block
`ifndef HPB_REGS_SVH
`define HPB_REGS_SVH
// Access type codes on the two-bit select field
`define HPB_ACC_CTRL     2'h0
`define HPB_ACC_DWIN_INC 2'h1
`define HPB_ACC_ADDR     2'h2
`define HPB_ACC_DWIN     2'h3
// Half-word select values
`define HPB_HW_FIRST     1'h0
`define HPB_HW_SECOND    1'h1
// Register index of the local port register file
`define HPB_IDX_CTRL     2'h0
`define HPB_IDX_ADDR     2'h1
`define HPB_IDX_DWIN     2'h2
// Reset values
`define HPB_CTRL_RST     32'h00000000
`define HPB_ADDR_RST     32'h00000000
// Clock period and the drive lead of data before ready low
`define HPB_CLK_PERIOD_NS 50
`define HPB_DATA_LEAD_NS  50
`define HPB_DATA_LEAD_CYC ((`HPB_DATA_LEAD_NS + `HPB_CLK_PERIOD_NS - 1) / `HPB_CLK_PERIOD_NS)
`endif

/* File: hw/hpb_pkg.sv */
// Types for the host port half-word handshake block
`default_nettype none
package hpb_pkg;
	// Select inputs captured at the start of an access
	typedef struct packed {
		logic [1:0] access_type_select;
		logic       read_write_select;
		logic       halfword_select;
	} hpb_sel_t;
	// Request toward the auxiliary transfer channel
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} hpb_aux_req_t;
	// Port state machine, gray coded along the read path
	typedef enum logic [2:0] {
		HPB_IDLE   = 3'b000,
		HPB_FETCH  = 3'b001,
		HPB_LEAD   = 3'b011,
		HPB_HOLD   = 3'b010,
		HPB_FLUSH  = 3'b110
	} hpb_state_t;
endpackage : hpb_pkg
`default_nettype wire

/* File: hw/hpb_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous pins
`default_nettype none
module hpb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	// First stage feeds only the second; runs through reset so pin levels are known in reset
	always_ff @(posedge clock) begin
		stage1   <= async_in;
		sync_out <= stage1;
	end
endmodule : hpb_sync
`default_nettype wire

/* File: hw/hpb_host_port.sv */
// Host access port: strobe combining, capture, bus drive and ready handshake
// What this block does
// - Combined strobe low when selected, strobes differ
// - Chip select high forces ready line low
// - Pending transfer shows busy when select falls
// - First read half-word of the data window issues auxiliary read
// - That data window read holds not-ready until word loaded
// - Busy after second half of data window write/increment read
// - Other accesses never signal busy
// - Control and address accesses leave ready alone
// - Select inputs captured at address strobe fall when used, else at strobe fall
// - Address strobe fall may show busy
// - Read drives data bus after strobe falls
// - Read data valid one cycle before ready
// - Bus released after strobe rises on read
// - Write data captured at strobe rise
// - In reset ready follows chip select inverted
`include "hpb_regs.svh"
`default_nettype none
module hpb_host_port (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  port_chip_select_n,
	input  wire logic                  data_strobe_a,
	input  wire logic                  data_strobe_b,
	input  wire logic                  address_strobe_n,
	input  wire logic                  address_strobe_used,
	input  wire logic [1:0]            access_type_select,
	input  wire logic                  read_write_select,
	input  wire logic                  halfword_select,
	input  wire logic [15:0]           port_data_bus_in,
	output var  logic [15:0]           port_data_bus_out,
	output var  logic                  port_data_bus_oe_n,
	output var  logic                  port_ready_n,
	output var  hpb_pkg::hpb_aux_req_t aux_req,
	input  wire logic                  aux_done,
	input  wire logic [31:0]           aux_rdata,
	output var  logic [31:0]           port_control_reg,
	output var  logic [31:0]           port_address_reg
);
	import hpb_pkg::*;

	logic [2:0]  pins_sync;
	logic        cs_n_s;
	logic        stb_raw_s;
	logic        as_n_s;
	logic        stb_d;
	logic        as_d;
	logic [20:0] sel_pins_s;
	logic [15:0] wdata_s;
	logic        as_used_s;
	logic [31:0] flush_word;
	hpb_state_t  state;
	hpb_state_t  next_state;
	hpb_sel_t    sel;
	hpb_sel_t    pin_sel;
	logic [31:0] data_window_reg;
	logic        pending;
	logic [1:0]  lead_cnt;
	logic        drive;

	// Raw strobe combine before crossing; the XOR glitches only while pins move
	wire comb_raw = ~(data_strobe_a ^ data_strobe_b) | port_chip_select_n;

	// Cross the three control pins into the clock domain
	hpb_sync #(.WIDTH(3)) u_sync (
		.clock    (clock),
		.async_in ({port_chip_select_n, comb_raw, address_strobe_n}),
		.sync_out (pins_sync)
	);
	// Select, data and mode pins also cross; they settle before the strobe edge is seen
	hpb_sync #(.WIDTH(21)) u_sync_sel (
		.clock    (clock),
		.async_in ({address_strobe_used, access_type_select, read_write_select, halfword_select, port_data_bus_in}),
		.sync_out (sel_pins_s)
	);
	assign as_used_s = sel_pins_s[20];
	assign wdata_s   = sel_pins_s[15:0];
	assign cs_n_s    = pins_sync[2];
	assign stb_raw_s = pins_sync[1];
	assign as_n_s    = pins_sync[0];

	// Edge decode on synchronised levels
	wire combined_host_strobe = stb_raw_s | cs_n_s;
	wire stb_fall = stb_d & ~combined_host_strobe;
	wire stb_rise = ~stb_d & combined_host_strobe;
	wire as_fall  = as_used_s & as_d & ~as_n_s;

	// Select pins are stable around the strobe fall, two cycles after the pin edge
	assign pin_sel = '{sel_pins_s[19:18], sel_pins_s[17], sel_pins_s[16]};

	function automatic logic is_dwin(input logic [1:0] t);
		is_dwin = (t == `HPB_ACC_DWIN) || (t == `HPB_ACC_DWIN_INC);
	endfunction : is_dwin

	wire cur_read   = sel.read_write_select;
	wire cur_first  = sel.halfword_select == `HPB_HW_FIRST;
	wire cur_dwin   = is_dwin(sel.access_type_select);
	wire cur_inc    = sel.access_type_select == `HPB_ACC_DWIN_INC;
	wire fall_read  = pin_sel.read_write_select;
	wire fall_dwin  = is_dwin(pin_sel.access_type_select);
	wire fall_first = pin_sel.halfword_select == `HPB_HW_FIRST;
	wire start_fetch = stb_fall && fall_read && fall_dwin && fall_first;
	// Only second half of a window write or increment read leaves work behind
	wire start_flush = stb_rise && !cur_first && cur_dwin && (!cur_read || cur_inc);

	// State sequencing
	always_comb begin
		next_state = state;
		case (state)
			HPB_IDLE: begin
				if (start_fetch) next_state = HPB_FETCH;
				else if (start_flush) next_state = HPB_FLUSH;
			end
			HPB_FETCH: begin
				if (aux_done) next_state = HPB_LEAD;
			end
			HPB_LEAD: begin
				if (lead_cnt == 2'(`HPB_DATA_LEAD_CYC - 1)) next_state = HPB_HOLD;
			end
			HPB_HOLD: begin
				if (stb_rise) next_state = start_flush ? HPB_FLUSH : HPB_IDLE;
			end
			HPB_FLUSH: begin
				if (aux_done) next_state = HPB_IDLE;
			end
			default: next_state = HPB_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) state <= HPB_IDLE;
		else state <= next_state;
	end

	// Edge history, lead counter and select capture
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stb_d    <= 1'b1;
			as_d     <= 1'b1;
			lead_cnt <= 2'h0;
			sel      <= '0;
		end else begin
			stb_d    <= combined_host_strobe;
			as_d     <= as_n_s;
			lead_cnt <= (state == HPB_LEAD) ? lead_cnt + 2'h1 : 2'h0;
			if (as_fall || (stb_fall && !as_used_s)) sel <= pin_sel;
		end
	end

	// Pending work covers the whole flush, seen at the next select or address fall
	assign pending = (state == HPB_FLUSH);

	// Registers and data window; write data taken at the strobe rise
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_control_reg <= `HPB_CTRL_RST;
			port_address_reg <= `HPB_ADDR_RST;
			data_window_reg  <= 32'h00000000;
		end else begin
			if (state == HPB_FETCH && aux_done) data_window_reg <= aux_rdata;
			if (stb_rise && !cur_read) begin
				case (sel.access_type_select)
					`HPB_ACC_CTRL: begin
						if (cur_first) port_control_reg[15:0] <= wdata_s;
						else port_control_reg[31:16] <= wdata_s;
					end
					`HPB_ACC_ADDR: begin
						if (cur_first) port_address_reg[15:0] <= wdata_s;
						else port_address_reg[31:16] <= wdata_s;
					end
					default: begin
						if (cur_first) data_window_reg[15:0] <= wdata_s;
						else data_window_reg[31:16] <= wdata_s;
					end
				endcase
			end
			if (state == HPB_FLUSH && aux_done && cur_inc) port_address_reg <= port_address_reg + 32'h4;
		end
	end

	// Upper half lands in the window on the same edge, so a write takes it from the pins
	assign flush_word = cur_read ? data_window_reg : {wdata_s, data_window_reg[15:0]};

	// Auxiliary request stays up until the channel answers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aux_req <= '0;
		end else if (aux_done) begin
			aux_req.valid <= 1'b0;
		end else if (start_fetch) begin
			aux_req <= '{1'b1, 1'b0, port_address_reg, 32'h00000000};
		end else if (start_flush) begin
			aux_req <= '{1'b1, !cur_read, port_address_reg, flush_word};
		end
	end

	// Read data selection
	wire [15:0] read_half =
		(sel.access_type_select == `HPB_ACC_CTRL) ? (cur_first ? port_control_reg[15:0] : port_control_reg[31:16]) :
		(sel.access_type_select == `HPB_ACC_ADDR) ? (cur_first ? port_address_reg[15:0] : port_address_reg[31:16]) :
		(cur_first ? data_window_reg[15:0] : data_window_reg[31:16]);
	wire data_ok = (state == HPB_HOLD) || (state == HPB_LEAD) || (!cur_dwin) || (!cur_first);

	// Bus drive from strobe fall to strobe rise on reads
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			drive              <= 1'b0;
			port_data_bus_oe_n <= 1'b1;
			port_data_bus_out  <= 16'h0000;
		end else begin
			if (stb_fall && fall_read) drive <= 1'b1;
			else if (stb_rise) drive <= 1'b0;
			port_data_bus_oe_n <= !((drive && !stb_rise) || (stb_fall && fall_read));
			port_data_bus_out  <= read_half;
		end
	end

	// Ready: busy during fetch, lead and flush; gated by chip select
	wire busy = (state == HPB_FETCH) || (state == HPB_LEAD) || pending
		|| (start_fetch) || (data_ok == 1'b0 && drive);
	always_ff @(posedge clock) begin
		if (!rst_n) port_ready_n <= !cs_n_s;
		else if (cs_n_s) port_ready_n <= 1'b0;
		else port_ready_n <= busy;
	end

	// Drive data one cycle before ready falls
	property p_lead;
		@(posedge clock) disable iff (!rst_n)
		(state == HPB_LEAD) |=> (state == HPB_HOLD);
	endproperty
	chk_read_data_lead: assert property (p_lead) else $error("lead not one cycle");
	chk_ready_cs_gate: assert property (@(posedge clock) disable iff (!rst_n)
		cs_n_s |=> !port_ready_n) else $error("ready not low with cs high");
	chk_fetch_issue: assert property (@(posedge clock) disable iff (!rst_n)
		start_fetch && !aux_done |=> aux_req.valid && !aux_req.write) else $error("no read request");
	sequence s_fetch_done;
		(state == HPB_FETCH) ##0 aux_done;
	endsequence
	chk_ready_after_load: assert property (@(posedge clock) disable iff (!rst_n)
		s_fetch_done ##1 !cs_n_s |=> port_ready_n) else $error("ready fell before data lead");
	chk_flush_busy: assert property (@(posedge clock) disable iff (!rst_n)
		start_flush && !cs_n_s |=> ##1 (port_ready_n || cs_n_s)) else $error("no busy after write");
	chk_ctrl_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		(state == HPB_IDLE) && stb_rise && !cur_dwin |=> state == HPB_IDLE) else $error("ctrl access busy");
	chk_bus_release: assert property (@(posedge clock) disable iff (!rst_n)
		stb_rise |=> port_data_bus_oe_n) else $error("bus not released");
	chk_bus_drive: assert property (@(posedge clock) disable iff (!rst_n)
		stb_fall && fall_read |=> !port_data_bus_oe_n) else $error("bus not driven");
	chk_pending_busy: assert property (@(posedge clock) disable iff (!rst_n)
		pending && !cs_n_s |=> port_ready_n || !pending) else $error("pending not busy");
endmodule : hpb_host_port
`default_nettype wire

/* File: verification/hpb_aux_model.sv */
// Behavioural auxiliary transfer channel answering the host port
`default_nettype none
module hpb_aux_model
	import hpb_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire hpb_aux_req_t req,
	input  wire logic [7:0]   delay,
	output var  logic         done,
	output var  logic [31:0]  rdata
);
	logic [31:0] mem [0:15];
	logic [31:0] word;
	logic [7:0]  cnt;
	logic        gap;
	// Known pattern so reads can be predicted
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'hA5000000 | i;
		end
	end
	// Outside the done pulse the read word is inverted, so stale data never matches
	assign rdata = done ? word : ~word;
	// Answer after a programmable wait; gap stops a second answer to the same request
	always @(posedge clock) begin
		if (!rst_n) begin
			done <= 1'b0;
			cnt  <= 8'h00;
			gap  <= 1'b0;
			word <= 32'h00000000;
		end else begin
			done <= 1'b0;
			gap  <= done;
			if (req.valid && !done && !gap) begin
				if (cnt >= delay) begin
					done <= 1'b1;
					cnt  <= 8'h00;
					word <= mem[req.addr[5:2]];
					if (req.write) mem[req.addr[5:2]] <= req.wdata;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule : hpb_aux_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the host port handshake block
`default_nettype none
module testbench;
	import hpb_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, rst_n = 1'b0, port_chip_select_n = 1'b1, data_strobe_a = 1'b0, data_strobe_b = 1'b0;
	logic address_strobe_n = 1'b1, address_strobe_used = 1'b0, read_write_select = 1'b0, halfword_select = 1'b0;
	logic [1:0]  access_type_select = 2'h0;
	logic [15:0] port_data_bus_in = 16'h0000, port_data_bus_out, rq;
	logic        port_data_bus_oe_n, port_ready_n, aux_done;
	logic [31:0] aux_rdata, port_control_reg, port_address_reg;
	logic [7:0]  delay = 8'h1E;
	hpb_aux_req_t aux_req;
	int err_total = 0, total_checks = 0, cycles = 0;
	hpb_host_port dut (.clock(clock), .rst_n(rst_n), .port_chip_select_n(port_chip_select_n),
		.data_strobe_a(data_strobe_a), .data_strobe_b(data_strobe_b), .address_strobe_n(address_strobe_n),
		.address_strobe_used(address_strobe_used), .access_type_select(access_type_select),
		.read_write_select(read_write_select), .halfword_select(halfword_select),
		.port_data_bus_in(port_data_bus_in), .port_data_bus_out(port_data_bus_out),
		.port_data_bus_oe_n(port_data_bus_oe_n), .port_ready_n(port_ready_n), .aux_req(aux_req),
		.aux_done(aux_done), .aux_rdata(aux_rdata), .port_control_reg(port_control_reg),
		.port_address_reg(port_address_reg));
	hpb_aux_model aux (.clock(clock), .rst_n(rst_n), .req(aux_req), .delay(delay), .done(aux_done), .rdata(aux_rdata));
	// 50 ns period
	always #25 clock = ~clock;
	// Hang guard, far beyond the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wait_ready;
		int n;
		n = 0;
		while (port_ready_n !== 1'b0 && n < 80) begin
			@(negedge clock);
			n++;
		end
		chk(n < 80, 1'b1);
	endtask : wait_ready
	// One half-word; bz is the ready level expected while the strobe is held
	task automatic xfer(input logic [1:0] t, input logic rd, hw, bz, input logic [15:0] wd, output logic [15:0] q);
		wait_ready();
		access_type_select = t;
		read_write_select  = rd;
		halfword_select    = hw;
		port_data_bus_in   = wd;
		repeat (2) @(negedge clock);
		if (address_strobe_used) address_strobe_n = 1'b0;
		repeat (2) @(negedge clock);
		data_strobe_a = 1'b1;
		repeat (6) @(negedge clock);
		chk(port_ready_n, bz);
		if (bz) chk({aux_req.valid, aux_req.write}, 2'h2);
		wait_ready();
		q = port_data_bus_out;
		if (rd) chk(port_data_bus_oe_n, 1'b0);
		data_strobe_a = 1'b0;
		repeat (2) @(negedge clock);
		address_strobe_n = 1'b1;
		repeat (3) @(negedge clock);
		if (rd) chk(port_data_bus_oe_n, 1'b1);
	endtask : xfer
	task automatic wr32(input logic [1:0] t, input logic [31:0] d);
		xfer(t, 1'b0, 1'b0, 1'b0, d[15:0], rq);
		xfer(t, 1'b0, 1'b1, 1'b0, d[31:16], rq);
	endtask : wr32
	task automatic rd32(input logic [1:0] t, input logic [31:0] exp);
		xfer(t, 1'b1, 1'b0, 1'b1, 16'h0000, rq);
		chk(rq, exp[15:0]);
		xfer(t, 1'b1, 1'b1, 1'b0, 16'h0000, rq);
		chk(rq, exp[31:16]);
	endtask : rd32
	task automatic test_idle(input logic in_rst);
		chk({port_ready_n, port_data_bus_oe_n}, 2'h1);
		data_strobe_a = 1'b1;
		repeat (8) @(negedge clock);
		chk({port_ready_n, port_data_bus_oe_n, aux_req.valid}, 3'h2);
		port_chip_select_n = 1'b0;
		data_strobe_b = 1'b1;
		repeat (8) @(negedge clock);
		chk({port_ready_n, port_data_bus_oe_n, aux_req.valid}, in_rst ? 3'h6 : 3'h2);
		data_strobe_a = 1'b0;
		data_strobe_b = 1'b0;
		repeat (3) @(negedge clock);
	endtask : test_idle
	task automatic test_regs;
		wr32(`HPB_ACC_CTRL, 32'h56781234);
		chk(port_control_reg, 32'h56781234);
		chk(port_ready_n, 1'b0);
		address_strobe_used = 1'b1;
		wr32(`HPB_ACC_ADDR, 32'h00000010);
		address_strobe_used = 1'b0;
		chk(port_address_reg, 32'h00000010);
		chk(port_ready_n, 1'b0);
	endtask : test_regs
	task automatic test_window;
		wr32(`HPB_ACC_DWIN, 32'hBEEF0C0D);
		chk(port_ready_n, 1'b1);
		port_chip_select_n = 1'b1;
		repeat (4) @(negedge clock);
		chk(port_ready_n, 1'b0);
		port_chip_select_n = 1'b0;
		repeat (4) @(negedge clock);
		chk(port_ready_n, 1'b1);
		wait_ready();
		chk(aux.mem[4], 32'hBEEF0C0D);
		rd32(`HPB_ACC_DWIN, 32'hBEEF0C0D);
		repeat (4) @(negedge clock);
		chk(port_ready_n, 1'b0);
		rd32(`HPB_ACC_DWIN_INC, 32'hBEEF0C0D);
		chk(port_ready_n, 1'b1);
		wait_ready();
		chk(port_address_reg, 32'h00000014);
		delay = 8'h02;
		rd32(`HPB_ACC_DWIN, 32'hA5000005);
	endtask : test_window
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (12) @(negedge clock);
		test_idle(1'b1);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		test_idle(1'b0);
		test_regs();
		test_window();
		test_done();
	end
endmodule : testbench
`default_nettype wire
